// ===== hw/acc_chain_comp.sv
// Acquisition chain compensation: three chains, masked control register,
// compensation and trim registers, startup load of the RC oscillator trim.
// Assumes converters and the factory trim source run on sys_clk.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/10ps
module acc_chain_comp import acc_pkg::*; #(
  parameter int RAW_W = ACC_RAW_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Register port
  input wire logic [ACC_ADDR_W-1:0] regAddr,
  input wire logic [ACC_DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [ACC_DATA_W-1:0] regRdData,
  // Factory RC trim value, stable from reset release
  input wire logic [ACC_TRIM_W-1:0] rcTrimFactory,
  // Raw converter samples
  input wire logic [ACC_NCH-1:0] rawValid,
  input wire logic [RAW_W-1:0] rawCurr,
  input wire logic [RAW_W-1:0] rawVolt,
  input wire logic [RAW_W-1:0] rawTemp,
  // Compensated results
  output logic currValid,
  output logic [RAW_W-1:0] currResult,
  output logic voltValid,
  output logic [RAW_W-1:0] voltResult,
  output logic tempValid,
  output logic [RAW_W-1:0] tempResult,
  // Trim values to the analog blocks, and the startup done flag
  output logic [ACC_TRIM_W-1:0] rcOscTrim,
  output logic [ACC_TRIM_W-1:0] lpOscTrim,
  output logic [ACC_TRIM_W-1:0] bandgapTrimA,
  output logic [ACC_TRIM_W-1:0] bandgapTrimB,
  output logic startupDone
);

  if (RAW_W > ACC_DATA_W || RAW_W < ACC_OFF_W) begin : g_chk
    $error("acc_chain_comp: RAW_W must lie between offset and data widths");
  end

  typedef struct packed {
    logic [ACC_NCH-1:0] ctrl;
    acc_vi_cfg_t volt;
    acc_vi_cfg_t curr;
    acc_t_cfg_t temp;
    logic [ACC_TRIM_W-1:0] rcTrim;
    logic [ACC_TRIM_W-1:0] lpTrim;
    logic [ACC_TRIM_W-1:0] bgA;
    logic [ACC_TRIM_W-1:0] bgB;
    acc_start_t start;
    logic [ACC_DATA_W-1:0] rdData;
  } top_t;

  top_t s_r;
  top_t s_nxt;
  acc_vi_cfg_t voltEff;
  acc_vi_cfg_t currEff;
  acc_t_cfg_t tempEff;

  // Zero-extend a narrow field onto the data bus
  function automatic logic [ACC_DATA_W-1:0] zx(input logic [ACC_DATA_W-1:0] v,
                                               input int w);
    zx = v & ((ACC_DATA_W'(1) << w) - ACC_DATA_W'(1));
  endfunction

  // Masked update of the control bits
  function automatic logic [ACC_NCH-1:0] maskWrite(input logic [ACC_NCH-1:0] cur,
                                                   input logic [ACC_DATA_W-1:0] wd);
    logic [ACC_NCH-1:0] m;
    m = wd[CTRL_MASK_SH +: ACC_NCH];
    maskWrite = (cur & ~m) | (wd[ACC_NCH-1:0] & m);
  endfunction

  // Disabled chains fall back to their default codes
  always_comb begin
    voltEff = s_r.ctrl[CH_V] ? s_r.volt
      : acc_vi_cfg_t'{gain: DEF_VI_GAIN, offset: DEF_OFF};
    currEff = s_r.ctrl[CH_I] ? s_r.curr
      : acc_vi_cfg_t'{gain: DEF_VI_GAIN, offset: DEF_OFF};
    tempEff = s_r.ctrl[CH_T] ? s_r.temp
      : acc_t_cfg_t'{gain: DEF_T_GAIN, offset: DEF_OFF};
  end

  // Register writes, reads and the startup sequencer
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdData = '0;
    case (s_r.start)
      ST_RESET: begin
        s_nxt.start = ST_LOAD;
      end
      ST_LOAD: begin
        s_nxt.rcTrim = rcTrimFactory;
        s_nxt.start = ST_DONE;
      end
      ST_DONE: begin
        s_nxt.start = ST_DONE;
      end
      default: begin
        s_nxt.start = ST_RESET;
      end
    endcase
    if (regWr) begin
      case (regAddr)
        ADR_CTRL1: s_nxt.ctrl = maskWrite(s_r.ctrl, regWrData);
        ADR_VGAIN: s_nxt.volt.gain = regWrData[ACC_VI_GAIN_W-1:0];
        ADR_VOFF: s_nxt.volt.offset = regWrData[ACC_OFF_W-1:0];
        ADR_IGAIN: s_nxt.curr.gain = regWrData[ACC_VI_GAIN_W-1:0];
        ADR_IOFF: s_nxt.curr.offset = regWrData[ACC_OFF_W-1:0];
        ADR_TGAIN: s_nxt.temp.gain = regWrData[ACC_T_GAIN_W-1:0];
        ADR_TOFF: s_nxt.temp.offset = regWrData[ACC_OFF_W-1:0];
        ADR_LPTRIM: s_nxt.lpTrim = regWrData[ACC_TRIM_W-1:0];
        ADR_BGA: s_nxt.bgA = regWrData[ACC_TRIM_W-1:0];
        ADR_BGB: s_nxt.bgB = regWrData[ACC_TRIM_W-1:0];
        default: begin
        end
      endcase
    end
    // Read data stands for one cycle only; unmapped words read zero
    if (regRd) begin
      case (regAddr)
        ADR_CTRL1: s_nxt.rdData = zx(ACC_DATA_W'(s_r.ctrl), ACC_NCH);
        ADR_VGAIN: s_nxt.rdData = zx(ACC_DATA_W'(s_r.volt.gain), ACC_VI_GAIN_W);
        ADR_VOFF: s_nxt.rdData = zx(ACC_DATA_W'(s_r.volt.offset), ACC_OFF_W);
        ADR_IGAIN: s_nxt.rdData = zx(ACC_DATA_W'(s_r.curr.gain), ACC_VI_GAIN_W);
        ADR_IOFF: s_nxt.rdData = zx(ACC_DATA_W'(s_r.curr.offset), ACC_OFF_W);
        ADR_TGAIN: s_nxt.rdData = zx(ACC_DATA_W'(s_r.temp.gain), ACC_T_GAIN_W);
        ADR_TOFF: s_nxt.rdData = zx(ACC_DATA_W'(s_r.temp.offset), ACC_OFF_W);
        ADR_RCTRIM: s_nxt.rdData = zx(ACC_DATA_W'(s_r.rcTrim), ACC_TRIM_W);
        ADR_LPTRIM: s_nxt.rdData = zx(ACC_DATA_W'(s_r.lpTrim), ACC_TRIM_W);
        ADR_BGA: s_nxt.rdData = zx(ACC_DATA_W'(s_r.bgA), ACC_TRIM_W);
        ADR_BGB: s_nxt.rdData = zx(ACC_DATA_W'(s_r.bgB), ACC_TRIM_W);
        ADR_VRES: s_nxt.rdData = ACC_DATA_W'(voltResult);
        ADR_IRES: s_nxt.rdData = ACC_DATA_W'(currResult);
        ADR_TRES: s_nxt.rdData = ACC_DATA_W'(tempResult);
        ADR_STAT: s_nxt.rdData = ACC_DATA_W'(s_r.start == ST_DONE);
        default: s_nxt.rdData = '0;
      endcase
    end
  end

  // Reset values; the RC trim is caught after release, not during reset
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_r.ctrl <= DEF_CTRL;
      s_r.volt <= '{gain: DEF_VI_GAIN, offset: DEF_OFF};
      s_r.curr <= '{gain: DEF_VI_GAIN, offset: DEF_OFF};
      s_r.temp <= '{gain: DEF_T_GAIN, offset: DEF_OFF};
      s_r.rcTrim <= DEF_TRIM;
      s_r.lpTrim <= DEF_TRIM;
      s_r.bgA <= DEF_TRIM;
      s_r.bgB <= DEF_TRIM;
      s_r.start <= ST_RESET;
      s_r.rdData <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // One stage per chain, each on its own converter
  acc_comp_stage #(.RAW_W(RAW_W), .GW(ACC_VI_GAIN_W), .GSH(ACC_VI_GSHIFT),
                   .OW(ACC_OFF_W)) u_curr (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .inValid(rawValid[CH_I]),
    .rawIn(rawCurr),
    .gain(currEff.gain),
    .offset(currEff.offset),
    .outValid(currValid),
    .result(currResult)
  );

  acc_comp_stage #(.RAW_W(RAW_W), .GW(ACC_VI_GAIN_W), .GSH(ACC_VI_GSHIFT),
                   .OW(ACC_OFF_W)) u_volt (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .inValid(rawValid[CH_V]),
    .rawIn(rawVolt),
    .gain(voltEff.gain),
    .offset(voltEff.offset),
    .outValid(voltValid),
    .result(voltResult)
  );

  acc_comp_stage #(.RAW_W(RAW_W), .GW(ACC_T_GAIN_W), .GSH(ACC_T_GSHIFT),
                   .OW(ACC_OFF_W)) u_temp (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .inValid(rawValid[CH_T]),
    .rawIn(rawTemp),
    .gain(tempEff.gain),
    .offset(tempEff.offset),
    .outValid(tempValid),
    .result(tempResult)
  );

  // Trim outputs straight from the registers
  assign rcOscTrim = s_r.rcTrim;
  assign lpOscTrim = s_r.lpTrim;
  assign bandgapTrimA = s_r.bgA;
  assign bandgapTrimB = s_r.bgB;
  assign startupDone = s_r.start[1]; // Only the done code has the high bit set
  assign regRdData = s_r.rdData;

  property p_rc_load;
    @(posedge sys_clk) disable iff (!nrst)
    s_r.start == ST_LOAD |=> rcOscTrim == $past(rcTrimFactory) && startupDone;
  endproperty
  a_rc_load: assert property (p_rc_load)
    else $error("RC trim not loaded from the factory value");

  property p_start_bound;
    @(posedge sys_clk) disable iff (!nrst)
    !$past(nrst) |-> ##2 startupDone;
  endproperty
  a_start_bound: assert property (p_start_bound)
    else $error("startup load not done two cycles after reset");

  property p_chain_indep;
    @(posedge sys_clk) disable iff (!nrst)
    rawValid[CH_V] && !rawValid[CH_I] |-> ##2 voltValid && !currValid;
  endproperty
  a_chain_indep: assert property (p_chain_indep)
    else $error("voltage and current chains not independent");

  property p_mask_hold;
    @(posedge sys_clk) disable iff (!nrst)
    regWr && regAddr == ADR_CTRL1 && !regWrData[CTRL_MASK_SH + CH_V]
    |=> s_r.ctrl[CH_V] == $past(s_r.ctrl[CH_V]);
  endproperty
  a_mask_hold: assert property (p_mask_hold)
    else $error("unmasked control bit changed");

  property p_temp_comp_enable_set;
    @(posedge sys_clk) disable iff (!nrst)
    regWr && regAddr == ADR_CTRL1 && regWrData[CTRL_MASK_SH + CH_T] && regWrData[CH_T]
    |=> s_r.ctrl[CH_T] ##1 (s_r.ctrl[CH_T] || $past(regWr));
  endproperty
  a_temp_comp_enable_set: assert property (p_temp_comp_enable_set)
    else $error("temperature compensation did not switch on");

  property p_temp_comp_enable_clr;
    @(posedge sys_clk) disable iff (!nrst)
    regWr && regAddr == ADR_CTRL1 && regWrData[CTRL_MASK_SH + CH_T] && !regWrData[CH_T]
    |=> !s_r.ctrl[CH_T] && tempEff.gain == DEF_T_GAIN;
  endproperty
  a_temp_comp_enable_clr: assert property (p_temp_comp_enable_clr)
    else $error("temperature compensation did not switch off");

  property p_volt_default;
    @(posedge sys_clk) disable iff (!nrst)
    !s_r.ctrl[CH_V] |-> voltEff.gain == DEF_VI_GAIN && voltEff.offset == DEF_OFF;
  endproperty
  a_volt_default: assert property (p_volt_default)
    else $error("disabled voltage chain not on default codes");

  property p_reset_codes;
    @(posedge sys_clk) disable iff (!nrst)
    !$past(nrst) |-> s_r.volt.gain == DEF_VI_GAIN && s_r.temp.gain == DEF_T_GAIN
      && s_r.curr.offset == DEF_OFF && s_r.ctrl == DEF_CTRL;
  endproperty
  a_reset_codes: assert property (p_reset_codes)
    else $error("compensation codes not at reset values");

  c_temp_on: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(s_r.ctrl[CH_T]));
  c_volt_comp: cover property (@(posedge sys_clk) disable iff (!nrst)
    voltValid && s_r.ctrl[CH_V]);
  c_started: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(startupDone));

endmodule

// ===== hw/acc_comp_stage.sv
// One compensation stage: raw sample times gain code, then offset added.
// Assumes raw samples arrive on sys_clk from the converter's decimator.
`timescale 1ns/10ps
module acc_comp_stage import acc_pkg::*; #(
  parameter int RAW_W = 16,
  parameter int GW = 10,
  parameter int GSH = 9,
  parameter int OW = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Raw sample and coefficients
  input wire logic inValid,
  input wire logic [RAW_W-1:0] rawIn,
  input wire logic [GW-1:0] gain,
  input wire logic [OW-1:0] offset,
  // Compensated sample
  output logic outValid,
  output logic [RAW_W-1:0] result
);

  localparam int PW = RAW_W + GW + 1;

  if (GSH >= GW || OW > RAW_W || RAW_W < 2) begin : g_chk
    $error("acc_comp_stage: unsupported width parameters");
  end

  typedef struct packed {
    logic v1;
    logic signed [PW-1:0] prod;
    logic signed [PW-1:0] offT;
    logic v2;
    logic [RAW_W-1:0] res;
  } stg_t;

  stg_t s_r;
  stg_t s_nxt;

  // Clamp a wide sum into the signed result range
  function automatic logic [RAW_W-1:0] clampRes(input logic signed [PW:0] v);
    logic signed [PW:0] hi;
    logic signed [PW:0] lo;
    hi = (PW+1)'((2 ** (RAW_W - 1)) - 1);
    lo = -hi - (PW+1)'(1);
    if (v > hi) begin
      clampRes = hi[RAW_W-1:0];
    end else if (v < lo) begin
      clampRes = lo[RAW_W-1:0];
    end else begin
      clampRes = v[RAW_W-1:0];
    end
  endfunction

  // Offset code moved into product scale, so gain never touches it
  function automatic logic signed [PW-1:0] offScale(input logic [OW-1:0] o);
    offScale = $signed({{(PW-OW){o[OW-1]}}, o}) <<< GSH;
  endfunction

  // Two stages: multiply first, add offset second
  always_comb begin
    logic signed [PW:0] sum;
    sum = '0;
    s_nxt = s_r;
    s_nxt.v1 = inValid;
    s_nxt.prod = PW'($signed(rawIn) * $signed({1'b0, gain}));
    s_nxt.offT = offScale(offset);
    sum = (PW+1)'(s_r.prod) + (PW+1)'(s_r.offT);
    s_nxt.v2 = s_r.v1;
    if (s_r.v1) begin
      s_nxt.res = clampRes(sum >>> GSH);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign outValid = s_r.v2;
  assign result = s_r.res;

  property p_gain_then_off;
    @(posedge sys_clk) disable iff (!nrst)
    inValid |-> ##2 outValid && result == clampRes(
      ((PW+1)'($signed($past(rawIn, 2)) * $signed({1'b0, $past(gain, 2)}))
      + (PW+1)'(offScale($past(offset, 2)))) >>> GSH);
  endproperty
  a_gain_then_off: assert property (p_gain_then_off)
    else $error("stage result does not match gain then offset");

  property p_unity_passes;
    @(posedge sys_clk) disable iff (!nrst)
    inValid && gain == GW'(2 ** GSH) && offset == '0 |-> ##2 result == $past(rawIn, 2);
  endproperty
  a_unity_passes: assert property (p_unity_passes)
    else $error("unity gain and zero offset altered the sample");

  property p_off_gain_free;
    @(posedge sys_clk) disable iff (!nrst)
    $changed(gain) && $stable(offset) |=> $stable(s_r.offT);
  endproperty
  a_off_gain_free: assert property (p_off_gain_free)
    else $error("offset term moved with the gain code");

endmodule

// ===== hw/acc_pkg.sv
// Package for the acquisition chain compensation block: register map,
// control bit layout, default codes and shared carrier types.
// Assumes a 16-bit register port with a 4-bit word address.
package acc_pkg;

  localparam int ACC_RAW_W = 16;
  localparam int ACC_DATA_W = 16;
  localparam int ACC_ADDR_W = 4;
  localparam int ACC_VI_GAIN_W = 10;
  localparam int ACC_T_GAIN_W = 8;
  localparam int ACC_OFF_W = 8;
  localparam int ACC_TRIM_W = 8;
  localparam int ACC_VI_GSHIFT = 9;
  localparam int ACC_T_GSHIFT = 7;

  // Register word addresses
  localparam logic [ACC_ADDR_W-1:0] ADR_CTRL1 = 4'h0;
  localparam logic [ACC_ADDR_W-1:0] ADR_VGAIN = 4'h1;
  localparam logic [ACC_ADDR_W-1:0] ADR_VOFF = 4'h2;
  localparam logic [ACC_ADDR_W-1:0] ADR_IGAIN = 4'h3;
  localparam logic [ACC_ADDR_W-1:0] ADR_IOFF = 4'h4;
  localparam logic [ACC_ADDR_W-1:0] ADR_TGAIN = 4'h5;
  localparam logic [ACC_ADDR_W-1:0] ADR_TOFF = 4'h6;
  localparam logic [ACC_ADDR_W-1:0] ADR_RCTRIM = 4'h7;
  localparam logic [ACC_ADDR_W-1:0] ADR_LPTRIM = 4'h8;
  localparam logic [ACC_ADDR_W-1:0] ADR_BGA = 4'h9;
  localparam logic [ACC_ADDR_W-1:0] ADR_BGB = 4'hA;
  localparam logic [ACC_ADDR_W-1:0] ADR_VRES = 4'hB;
  localparam logic [ACC_ADDR_W-1:0] ADR_IRES = 4'hC;
  localparam logic [ACC_ADDR_W-1:0] ADR_TRES = 4'hD;
  localparam logic [ACC_ADDR_W-1:0] ADR_STAT = 4'hE;

  // Control register 1: enables in low bits, masks above
  localparam int CH_T = 0;
  localparam int CH_V = 1;
  localparam int CH_I = 2;
  localparam int ACC_NCH = 3;
  localparam int CTRL_MASK_SH = 8;

  // Reset and disabled-compensation codes
  localparam logic [ACC_VI_GAIN_W-1:0] DEF_VI_GAIN = 10'h200;
  localparam logic [ACC_T_GAIN_W-1:0] DEF_T_GAIN = 8'h80;
  localparam logic [ACC_OFF_W-1:0] DEF_OFF = 8'h00;
  localparam logic [ACC_TRIM_W-1:0] DEF_TRIM = 8'h00;
  localparam logic [ACC_NCH-1:0] DEF_CTRL = 3'h0;

  // Startup sequencer
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_LOAD = 2'b01,
    ST_DONE = 2'b10
  } acc_start_t;

  // Gain and offset of one voltage or current chain
  typedef struct packed {
    logic [ACC_VI_GAIN_W-1:0] gain;
    logic [ACC_OFF_W-1:0] offset;
  } acc_vi_cfg_t;

  // Gain and offset of the temperature chain
  typedef struct packed {
    logic [ACC_T_GAIN_W-1:0] gain;
    logic [ACC_OFF_W-1:0] offset;
  } acc_t_cfg_t;

endpackage

// ===== tb/acc_chain_comp_test.sv
// Self-checking bench for the acquisition chain compensation block.
// Assumes the register port and converter model share one 100 MHz clock.
`timescale 1ns/10ps
module acc_chain_comp_test import acc_pkg::*; ;
  localparam logic [7:0] FACT_TRIM = 8'h5A; // arbitrary factory code
  logic sys_clk, nrst, regWr, regRd, startupDone;
  logic [ACC_ADDR_W-1:0] regAddr;
  logic [15:0] regWrData, regRdData, rawCurr, rawVolt, rawTemp;
  logic [15:0] currResult, voltResult, tempResult;
  logic [7:0] rcTrimFactory, rcOscTrim, lpOscTrim, bandgapTrimA, bandgapTrimB;
  logic [2:0] rawValid;
  logic currValid, voltValid, tempValid;
  logic [15:0] rd;
  int badCount, compares;
  logic [15:0] resetTab [7] = '{16'h0000, 16'h0200, 16'h0000, 16'h0200, 16'h0000,
                                16'h0080, 16'h0000};
  logic [15:0] ctrlWr [7] = '{16'h0101, 16'h0001, 16'h0100, 16'h0707, 16'h0200,
                              16'h0000, 16'h0700};
  logic [15:0] ctrlExp [7] = '{16'h0001, 16'h0001, 16'h0000, 16'h0007, 16'h0005,
                               16'h0005, 16'h0000};

  acc_conv_model conv (.sys_clk(sys_clk), .rawValid(rawValid), .rawCurr(rawCurr),
    .rawVolt(rawVolt), .rawTemp(rawTemp));

  acc_chain_comp DUT (.sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .rcTrimFactory(rcTrimFactory), .rawValid(rawValid), .rawCurr(rawCurr),
    .rawVolt(rawVolt), .rawTemp(rawTemp), .currValid(currValid),
    .currResult(currResult), .voltValid(voltValid), .voltResult(voltResult),
    .tempValid(tempValid), .tempResult(tempResult), .rcOscTrim(rcOscTrim),
    .lpOscTrim(lpOscTrim), .bandgapTrimA(bandgapTrimA), .bandgapTrimB(bandgapTrimB),
    .startupDone(startupDone));

  // Free-running system clock
  always #5 sys_clk = ~sys_clk;

  // Compare tasks, one per result width
  task automatic chkWord(input string what, input logic [15:0] exp, got);
    compares++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic chkByte(input string what, input logic [7:0] exp, got);
    compares++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic chkFlag(input string what, input logic exp, got);
    compares++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  // Register port cycles; strobes last exactly one cycle
  task automatic wrReg(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rdChk(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    chkWord(what, exp, regRdData);
  endtask

  // Reference math: gain first, then offset in result LSBs, saturated
  function automatic logic [15:0] expComp(input logic signed [15:0] raw, input int gain,
                                          input logic signed [7:0] off, input int sh);
    longint p;
    p = (longint'(raw) * gain + (longint'(off) <<< sh)) >>> sh;
    if (p > 32767) p = 32767;
    else if (p < -32768) p = -32768;
    return p[15:0];
  endfunction

  // Send samples, then expect results exactly two cycles later
  task automatic smp(input logic [2:0] sel, input logic [15:0] c, v, t, ec, ev, et);
    conv.send(sel, c, v, t);
    #1;
    chkFlag("voltValid early", 1'b0, voltValid);
    @(posedge sys_clk);
    #1;
    chkFlag("currValid", sel[CH_I], currValid);
    chkFlag("voltValid", sel[CH_V], voltValid);
    chkFlag("tempValid", sel[CH_T], tempValid);
    if (sel[CH_I]) chkWord("currResult", ec, currResult);
    if (sel[CH_V]) chkWord("voltResult", ev, voltResult);
    if (sel[CH_T]) chkWord("tempResult", et, tempResult);
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Watchdog; the tests need about a hundred cycles
  initial begin
    repeat (3000) @(posedge sys_clk);
    badCount++;
    $display("unexpected watchdog expiry");
    summarize();
  end

  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    regAddr = '0;
    regWrData = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    rcTrimFactory = FACT_TRIM;
    badCount = 0;
    compares = 0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    chkFlag("startupDone in reset", 1'b0, startupDone);
    repeat (2) @(posedge sys_clk);
    #1;
    chkFlag("startupDone", 1'b1, startupDone);
    chkByte("rcOscTrim", FACT_TRIM, rcOscTrim);
    for (int i = 0; i < 7; i++) rdChk(i[3:0], resetTab[i], "reset value");
    rdChk(ADR_STAT, 16'h0001, "status");
    rdChk(4'hF, 16'h0000, "unmapped");
    wrReg(ADR_RCTRIM, 16'h00FF); // read-only place, must be ignored
    rdChk(ADR_RCTRIM, {8'h00, FACT_TRIM}, "rc trim readback");
    $display("test startup and reset values done");
    // Firmware copy of factory trims, once after power-on
    wrReg(ADR_LPTRIM, 16'h0011);
    wrReg(ADR_BGA, 16'h0022);
    wrReg(ADR_BGB, 16'h0033);
    rdChk(ADR_BGB, 16'h0033, "bandgap B readback");
    chkByte("lpOscTrim", 8'h11, lpOscTrim);
    chkByte("bandgapTrimA", 8'h22, bandgapTrimA);
    chkByte("bandgapTrimB", 8'h33, bandgapTrimB);
    $display("test trim copy done");
    // Masked control writes: only bits with mask set may change
    for (int i = 0; i < 7; i++) begin
      wrReg(ADR_CTRL1, ctrlWr[i]);
      rdChk(ADR_CTRL1, ctrlExp[i], "control readback");
    end
    $display("test masked control done");
    // Voltage chain: defaults used while off, register codes once enabled
    wrReg(ADR_VGAIN, 16'h0300);
    wrReg(ADR_VOFF, 16'h0010);
    smp(3'b010, 16'h0, 16'h0100, 16'h0, 16'h0, expComp(16'h0100, 'h200, 8'h00, 9),
        16'h0);
    wrReg(ADR_CTRL1, 16'h0202);
    smp(3'b010, 16'h0, 16'h0100, 16'h0, 16'h0, expComp(16'h0100, 'h300, 8'h10, 9),
        16'h0);
    smp(3'b010, 16'h0, 16'h0000, 16'h0, 16'h0, 16'h0010, 16'h0);
    wrReg(ADR_VGAIN, 16'h0100);
    smp(3'b010, 16'h0, 16'h0000, 16'h0, 16'h0, 16'h0010, 16'h0);
    smp(3'b010, 16'h0, 16'hFF00, 16'h0, 16'h0, expComp(16'hFF00, 'h100, 8'h10, 9),
        16'h0);
    $display("test voltage chain done");
    // All three chains at once, each with its own codes
    wrReg(ADR_CTRL1, 16'h0707);
    wrReg(ADR_IGAIN, 16'h0180);
    wrReg(ADR_IOFF, 16'h0005);
    wrReg(ADR_TGAIN, 16'h0090);
    wrReg(ADR_TOFF, 16'h00F0);
    smp(3'b111, 16'hFF00, 16'h1234, 16'h0040, expComp(16'hFF00, 'h180, 8'h05, 9),
        expComp(16'h1234, 'h100, 8'h10, 9), expComp(16'h0040, 'h90, 8'hF0, 7));
    rdChk(ADR_IRES, expComp(16'hFF00, 'h180, 8'h05, 9), "current result readback");
    rdChk(ADR_VRES, expComp(16'h1234, 'h100, 8'h10, 9), "voltage result readback");
    rdChk(ADR_TRES, expComp(16'h0040, 'h90, 8'hF0, 7), "temp result readback");
    $display("test three chains done");
    summarize();
  end
endmodule

// ===== tb/acc_conv_model.sv
// Behavioural model of the three sigma delta converters feeding the chains.
// Assumes the bench calls send() and that samples share sys_clk.
`timescale 1ns/10ps
module acc_conv_model import acc_pkg::*; (
  // Clock
  input wire logic sys_clk,
  // Raw samples, one strobe per chain
  output logic [ACC_NCH-1:0] rawValid,
  output logic [ACC_RAW_W-1:0] rawCurr,
  output logic [ACC_RAW_W-1:0] rawVolt,
  output logic [ACC_RAW_W-1:0] rawTemp
);
  // Quiet lines at time zero
  initial begin
    rawValid = '0;
    rawCurr = 16'h0000;
    rawVolt = 16'h0000;
    rawTemp = 16'h0000;
  end

  // One sample per selected converter, each with its own data line
  // Data lines flip after the strobe so a stale sample never looks valid
  task automatic send(input logic [ACC_NCH-1:0] sel, input logic [15:0] c, v, t);
    @(posedge sys_clk);
    rawValid <= sel;
    rawCurr <= c;
    rawVolt <= v;
    rawTemp <= t;
    @(posedge sys_clk);
    rawValid <= '0;
    rawCurr <= ~c;
    rawVolt <= ~v;
    rawTemp <= ~t;
  endtask
endmodule
